// *** hdl/stepper_cmd_pkg.sv ***
// Shared constants for the stepper command interpreter: widths, command
// codes, status word layout, timing counts and the motion state type.
// Assumes a single 125 MHz system clock.
package stepper_cmd_pkg;
	localparam int CLK_MHZ       = 125;
	localparam int TICK_NS       = 250;
	localparam int TICK_CYCLES   = (TICK_NS * CLK_MHZ) / 1000;
	localparam int POS_W         = 22;
	localparam int SPD_W         = 20;
	localparam int ACC_W         = 12;
	localparam int FRAC_W        = 28;
	localparam int WARN_W        = 4;
	localparam int ARG_BYTES_DEF = 3;
	localparam int SLOW_RATE_SPS = 5;
	// Slow creep rate as a 0.28 step/tick value
	localparam logic [SPD_W-1:0] SLOW_SPEED = SPD_W'((64'(SLOW_RATE_SPS) * 64'(TICK_NS)
		* (64'h1 << FRAC_W)) / 64'd1000000000);

	// Command codes; DIR sits in bit 0, ACT in bit 3
	localparam logic [7:0] OP_NOP          = 8'h00;
	localparam logic [7:0] OP_MOVE_DIR     = 8'h68;
	localparam logic [7:0] OP_RUN_SWITCH   = 8'h82;
	localparam logic [7:0] OP_RELEASE_SW   = 8'h92;
	localparam logic [7:0] OP_GO_ZERO      = 8'h70;
	localparam logic [7:0] OP_GO_MARKER    = 8'h78;
	localparam logic [7:0] OP_POS_CLEAR    = 8'hD8;
	localparam logic [7:0] OP_REINIT       = 8'hC0;
	localparam logic [7:0] OP_DECEL_STOP   = 8'hB0;
	localparam logic [7:0] OP_ABRUPT_STOP  = 8'hB8;
	localparam logic [7:0] OP_DECEL_FLOAT  = 8'hA0;
	localparam logic [7:0] OP_IMM_FLOAT    = 8'hA8;
	localparam logic [7:0] OP_STATUS_READ  = 8'hD0;
	localparam logic [7:0] MASK_DIR        = 8'hFE;
	localparam logic [7:0] MASK_ACT_DIR    = 8'hF6;

	// Status word bit positions
	localparam int SB_HIZ    = 0;
	localparam int SB_BUSY_N = 1;
	localparam int SB_SW     = 2;
	localparam int SB_SW_EVT = 3;
	localparam int SB_DIR    = 4;
	localparam int SB_MOT    = 5;
	localparam int SB_REJ    = 7;
	localparam int SB_WRONG  = 8;
	localparam int SB_WARN   = 9;
	localparam int SB_ERR    = 13;

	localparam logic [1:0] MOT_STOP  = 2'h0;
	localparam logic [1:0] MOT_ACC   = 2'h1;
	localparam logic [1:0] MOT_DEC   = 2'h2;
	localparam logic [1:0] MOT_CONST = 2'h3;

	typedef enum logic [2:0] {
		MS_IDLE, MS_ABSOLUTE_MOVE, MS_UNTIL, MS_RELEASE, MS_DECEL, MS_DECEL_FLOAT
	} motion_state_t;
endpackage

// *** hdl/cmd_arg_collect.sv ***
// Collects the argument bytes that follow a command byte, MSB first.
// Assumes byteValid is a one-cycle strobe per received byte.
`timescale 1ns/1ps
module cmd_arg_collect
	import stepper_cmd_pkg::*;
#(
	parameter int ARG_BYTES = ARG_BYTES_DEF
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   clkEn,
	input  wire logic                   clr,
	input  wire logic                   start,
	input  wire logic [7:0]             opIn,
	input  wire logic                   byteValid,
	input  wire logic [7:0]             byteIn,
	output logic                        active,
	output logic                        done,
	output logic [7:0]                  op,
	output logic [8*ARG_BYTES-1:0]      value
);
	localparam int CW = $clog2(ARG_BYTES + 1);
	logic [CW-1:0] count_q;
	logic          take;

	assign take   = active && byteValid;
	assign active = count_q != '0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			done    <= 1'b0;
			op      <= 8'h00;
			value   <= '0;
		end else if (clkEn) begin
			done <= 1'b0;
			if (clr) begin
				count_q <= '0;
			end else if (start) begin
				count_q <= CW'(ARG_BYTES);
				op      <= opIn;
			end else if (take) begin
				value   <= {value[8*ARG_BYTES-9:0], byteIn};
				count_q <= count_q - 1'b1;
				done    <= count_q == CW'(1);
			end
		end
	end
endmodule

// *** hdl/step_rate_gen.sv ***
// Speed ramp and step generator: speed in 0.28 step/tick, one tick
// every TICK_CYC clocks, a step on each phase accumulator carry.
`timescale 1ns/1ps
module step_rate_gen
	import stepper_cmd_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             clkEn,
	input  wire logic             clr,
	input  wire logic             abrupt_stop,
	input  wire logic [SPD_W-1:0] targetSpeed,
	input  wire logic [ACC_W-1:0] accelStep,
	input  wire logic [ACC_W-1:0] decelStep,
	output logic      [SPD_W-1:0] speed,
	output logic                  stepTick,
	output logic                  stopped
);
	localparam int CNT_W = $clog2(TICK_CYC) + 1;
	logic [CNT_W-1:0]  tickCnt_q;
	logic [FRAC_W-1:0] phase_q;
	logic              tick;
	logic [SPD_W:0]    speedUp;
	logic [SPD_W:0]    floorDown;
	logic [SPD_W-1:0]  speed_d;
	logic [FRAC_W:0]   phaseSum;

	assign tick      = tickCnt_q == CNT_W'(TICK_CYC - 1);
	assign speedUp   = (SPD_W+1)'(speed) + (SPD_W+1)'(accelStep);
	assign floorDown = (SPD_W+1)'(targetSpeed) + (SPD_W+1)'(decelStep);
	assign speed_d   = (speed < targetSpeed)
		? ((speedUp > (SPD_W+1)'(targetSpeed)) ? targetSpeed : speedUp[SPD_W-1:0])
		: (((SPD_W+1)'(speed) > floorDown) ? speed - SPD_W'(decelStep) : targetSpeed);
	assign phaseSum  = (FRAC_W+1)'(phase_q) + (FRAC_W+1)'(speed);
	assign stopped   = speed == '0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_q <= '0;
			phase_q   <= '0;
			speed     <= '0;
			stepTick  <= 1'b0;
		end else if (clkEn) begin
			stepTick  <= 1'b0;
			tickCnt_q <= tick ? '0 : tickCnt_q + 1'b1;
			// Infinite deceleration: speed and phase drop at once
			if (clr || abrupt_stop) begin
				speed   <= '0;
				phase_q <= '0;
			end else if (tick) begin
				speed    <= speed_d;
				phase_q  <= phaseSum[FRAC_W-1:0];
				stepTick <= phaseSum[FRAC_W];
			end
		end
	end
endmodule

// *** hdl/stepper_cmd_core.sv ***
// Stepper motion command interpreter: decodes received command bytes,
// runs positioning, switch homing, stop and float sequences, and
// answers status reads. Assumes a byte framer delivers rxByte with a
// one-cycle rxValid and shifts txByte out during the next byte.
`timescale 1ns/1ps
module stepper_cmd_core
	import stepper_cmd_pkg::*;
#(
	parameter int TICK_CYC  = TICK_CYCLES,
	parameter int ARG_BYTES = ARG_BYTES_DEF
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	input  wire logic              rxValid,
	input  wire logic [7:0]        rxByte,
	input  wire logic              swClosed,
	input  wire logic              switchStopSelect,
	input  wire logic              lowSpeedOpt,
	input  wire logic [SPD_W-1:0]  maxSpeed,
	input  wire logic [SPD_W-1:0]  minSpeed,
	input  wire logic [ACC_W-1:0]  accelValue,
	input  wire logic [ACC_W-1:0]  decelerationRegister,
	input  wire logic [WARN_W-1:0] warnEvt,
	input  wire logic              faultEvt,
	output logic      [7:0]        txByte,
	output logic                   busyN,
	output logic                   commandRejectedFlag,
	output logic                   wrongCommandFlag,
	output logic                   highImpedanceFlag,
	output logic                   bridgeEnable,
	output logic                   stepPulse,
	output logic                   stepDir,
	output logic      [POS_W-1:0]  absolutePosition,
	output logic      [POS_W-1:0]  markPosition,
	output logic      [15:0]       statusWord
);
	motion_state_t state_q, state_d;
	logic              collecting, argDone;
	logic [7:0]        argOp;
	logic [8*ARG_BYTES-1:0] argValue;
	logic [SPD_W-1:0]  curSpeed, engineTarget, untilSpeed_q, untilSpeed_d;
	logic [SPD_W-1:0]  argSpeed, creepSpeed, relSpeed;
	logic              stepTick, stopped, busy;
	logic              cmdByte, opMoveDir, opUntil, opRelease, opZero, opMark;
	logic              opClear, opReinit, opSoftStop, opHardStop, opSoftFloat;
	logic              opHardFloat, opStatus, isKnown, unknownEvt, reinit;
	logic              argIsUntil, execMoveDir, execUntil, execRelease;
	logic              execGoZero, execGoMark, posRequest, rejectEvt, startPos;
	logic              softStopCmd, hardStopCmd, softFloatCmd, hardFloatCmd, statusCmd;
	logic [POS_W-1:0]  reqTarget, reqDiff, target_q, target_d, diff, remaining;
	logic [POS_W-1:0]  absPos_d, markPos_d, accelSteps_q, accelSteps_d;
	logic              reqDir, atTarget, nearEnd, dir_q, dir_d;
	logic              swPrev_q, swTurnOn, switchHit, releaseHit, swAction;
	logic              act_q, act_d, positionClear, markLoad, hardStopEvt, stepApply;
	logic              bridge_d, rej_d, wrong_d, err_q, err_d, swEvt_q, swEvt_d;
	logic [WARN_W-1:0] warn_q, warn_d;
	logic [1:0]        motStatus;
	logic [7:0]        respByte_q;
	logic              respPending_q;

	cmd_arg_collect #(
		.ARG_BYTES (ARG_BYTES)
	) u_args (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.clkEn     (clkEn),
		.clr       (reinit),
		.start     (cmdByte && (opMoveDir || opUntil)),
		.opIn      (rxByte),
		.byteValid (rxValid),
		.byteIn    (rxByte),
		.active    (collecting),
		.done      (argDone),
		.op        (argOp),
		.value     (argValue)
	);

	step_rate_gen #(
		.TICK_CYC (TICK_CYC)
	) u_engine (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clkEn       (clkEn),
		.clr         (reinit),
		.abrupt_stop    (hardStopEvt),
		.targetSpeed (engineTarget),
		.accelStep   (accelValue),
		.decelStep   (decelerationRegister),
		.speed       (curSpeed),
		.stepTick    (stepTick),
		.stopped     (stopped)
	);

	assign cmdByte     = rxValid && !collecting;
	assign opMoveDir   = (rxByte & MASK_DIR) == OP_MOVE_DIR;
	assign opUntil     = (rxByte & MASK_ACT_DIR) == OP_RUN_SWITCH;
	assign opRelease   = (rxByte & MASK_ACT_DIR) == OP_RELEASE_SW;
	assign opZero      = rxByte == OP_GO_ZERO;
	assign opMark      = rxByte == OP_GO_MARKER;
	assign opClear     = rxByte == OP_POS_CLEAR;
	assign opReinit    = rxByte == OP_REINIT;
	assign opSoftStop  = rxByte == OP_DECEL_STOP;
	assign opHardStop  = rxByte == OP_ABRUPT_STOP;
	assign opSoftFloat = rxByte == OP_DECEL_FLOAT;
	assign opHardFloat = rxByte == OP_IMM_FLOAT;
	assign opStatus    = rxByte == OP_STATUS_READ;
	assign isKnown     = opMoveDir || opUntil || opRelease || opZero || opMark || opClear
		|| opReinit || opSoftStop || opHardStop || opSoftFloat || opHardFloat
		|| opStatus || (rxByte == OP_NOP);
	assign unknownEvt  = cmdByte && !isKnown;
	assign argIsUntil  = (argOp & MASK_ACT_DIR) == OP_RUN_SWITCH;

	assign reinit       = cmdByte && opReinit;
	assign softStopCmd  = cmdByte && opSoftStop;
	assign hardStopCmd  = cmdByte && opHardStop;
	assign softFloatCmd = cmdByte && opSoftFloat;
	assign hardFloatCmd = cmdByte && opHardFloat;
	assign statusCmd    = cmdByte && opStatus;
	assign execMoveDir  = argDone && !argIsUntil;
	assign execUntil    = argDone && argIsUntil;
	assign execRelease  = cmdByte && opRelease;
	assign execGoZero   = cmdByte && opZero;
	assign execGoMark   = cmdByte && opMark;

	// busy covers motion states and a turning motor
	assign busy  = (state_q != MS_IDLE) || !stopped;
	assign busyN = !busy;

	// position moves need an idle motor
	assign posRequest = execMoveDir || execGoZero || execGoMark;
	assign rejectEvt  = posRequest && busy;
	assign startPos   = posRequest && !busy;

	assign reqTarget = execMoveDir ? argValue[POS_W-1:0]
		: (execGoMark ? markPosition : '0);
	assign reqDiff   = reqTarget - absolutePosition;
	// bit 0 forces direction, otherwise shortest path
	assign reqDir    = execMoveDir ? argOp[0] : !reqDiff[POS_W-1];
	assign diff      = target_q - absolutePosition;
	assign remaining = dir_q ? diff : '0 - diff;
	assign atTarget  = remaining == '0;
	// Stop distance mirrors the ramp-up distance; exact only when acc equals dec
	assign nearEnd   = remaining <= accelSteps_q;

	// speed argument is the low bits of a 0.28 value
	assign argSpeed   = argValue[SPD_W-1:0];
	assign untilSpeed_d = reinit ? '0 : !execUntil ? untilSpeed_q
		: (argSpeed > maxSpeed) ? maxSpeed
		: (argSpeed < minSpeed) ? minSpeed : argSpeed;
	assign creepSpeed = (minSpeed < SLOW_SPEED) ? SLOW_SPEED : minSpeed;
	assign relSpeed   = lowSpeedOpt ? SLOW_SPEED : creepSpeed;

	// closing edge ends the homing run
	assign swTurnOn   = swClosed && !swPrev_q;
	assign switchHit  = (state_q == MS_UNTIL) && swTurnOn;
	// level, so an already open switch ends at once
	assign releaseHit = (state_q == MS_RELEASE) && !swClosed;
	assign swAction   = switchHit || releaseHit;
	// clear by command or by switch action with ACT clear
	assign positionClear = (cmdByte && opClear) || (swAction && !act_q);
	assign markLoad      = swAction && act_q;

	assign hardStopEvt = hardStopCmd || hardFloatCmd || faultEvt || reinit
		|| (switchHit && !switchStopSelect) || releaseHit
		|| ((state_q == MS_ABSOLUTE_MOVE) && atTarget);
	assign stepApply   = stepTick && bridgeEnable
		&& !((state_q == MS_ABSOLUTE_MOVE) && atTarget);

	assign absPos_d  = (reinit || positionClear) ? '0
		: !stepApply ? absolutePosition
		: (dir_q ? absolutePosition + 1'b1 : absolutePosition - 1'b1);
	assign markPos_d = reinit ? '0 : (markLoad ? absolutePosition : markPosition);
	assign target_d  = reinit ? '0 : (startPos ? reqTarget : target_q);
	assign act_d     = reinit ? 1'b0 : execUntil ? argOp[3]
		: execRelease ? rxByte[3] : act_q;
	assign dir_d     = reinit ? 1'b0 : startPos ? reqDir : execUntil ? argOp[0]
		: execRelease ? rxByte[0] : dir_q;
	assign accelSteps_d = (reinit || startPos) ? '0
		: (stepApply && (state_q == MS_ABSOLUTE_MOVE) && !nearEnd && (curSpeed < maxSpeed))
		? accelSteps_q + 1'b1 : accelSteps_q;

	always_comb begin
		engineTarget = '0;
		case (state_q)
			MS_ABSOLUTE_MOVE: begin
				engineTarget = nearEnd ? creepSpeed : maxSpeed;
			end
			MS_UNTIL: begin
				engineTarget = untilSpeed_q;
			end
			MS_RELEASE: begin
				engineTarget = relSpeed;
			end
			default: begin
				// ramp to zero with deceleration value
				engineTarget = '0;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			MS_ABSOLUTE_MOVE: begin
				if (atTarget) state_d = MS_IDLE;
			end
			MS_UNTIL: begin
				// stop kind picked by switch stop select
				if (switchHit) state_d = switchStopSelect ? MS_DECEL : MS_IDLE;
			end
			MS_RELEASE: begin
				if (releaseHit) state_d = MS_IDLE;
			end
			MS_DECEL, MS_DECEL_FLOAT: begin
				if (stopped) state_d = MS_IDLE;
			end
			default: begin
				state_d = state_q;
			end
		endcase
		// stop and float commands override any motion
		if (reinit || faultEvt || hardStopCmd || hardFloatCmd) begin
			state_d = MS_IDLE;
		end else if (softStopCmd) begin
			state_d = highImpedanceFlag ? MS_IDLE : MS_DECEL;
		end else if (softFloatCmd) begin
			state_d = stopped ? MS_IDLE : MS_DECEL_FLOAT;
		end else if (execUntil) begin
			state_d = MS_UNTIL;
		end else if (execRelease) begin
			state_d = MS_RELEASE;
		end else if (startPos) begin
			state_d = MS_ABSOLUTE_MOVE;
		end
	end

	assign bridge_d = (reinit || faultEvt || hardFloatCmd || (softFloatCmd && stopped)
		|| ((state_q == MS_DECEL_FLOAT) && stopped)) ? 1'b0
		: (softStopCmd || hardStopCmd || execUntil || execRelease || startPos)
		? 1'b1 : bridgeEnable;
	assign highImpedanceFlag = !bridgeEnable;

	// status read clears flags, a same-cycle event still sets
	assign rej_d   = !reinit && (rejectEvt || (commandRejectedFlag && !statusCmd));
	assign wrong_d = !reinit && (unknownEvt || (wrongCommandFlag && !statusCmd));
	assign err_d   = !reinit && (faultEvt || (err_q && !statusCmd));
	assign swEvt_d = !reinit && (swTurnOn || (swEvt_q && !statusCmd));
	assign warn_d  = reinit ? '0 : warnEvt | (warn_q & ~{WARN_W{statusCmd}});

	assign motStatus = stopped ? MOT_STOP : (curSpeed < engineTarget) ? MOT_ACC
		: (curSpeed > engineTarget) ? MOT_DEC : MOT_CONST;

	always_comb begin
		statusWord                      = '0;
		statusWord[SB_HIZ]              = highImpedanceFlag;
		statusWord[SB_BUSY_N]           = busyN;
		statusWord[SB_SW]               = swClosed;
		statusWord[SB_SW_EVT]           = swEvt_q;
		statusWord[SB_DIR]              = dir_q;
		statusWord[SB_MOT +: 2]         = motStatus;
		statusWord[SB_REJ]              = commandRejectedFlag;
		statusWord[SB_WRONG]            = wrongCommandFlag;
		statusWord[SB_WARN +: WARN_W]   = warn_q;
		statusWord[SB_ERR]              = err_q;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q             <= MS_IDLE;
			bridgeEnable        <= 1'b0;
			absolutePosition    <= '0;
			markPosition        <= '0;
			target_q            <= '0;
			accelSteps_q        <= '0;
			untilSpeed_q        <= '0;
			dir_q               <= 1'b0;
			act_q               <= 1'b0;
			swPrev_q            <= 1'b0;
		end else if (clkEn) begin
			state_q             <= state_d;
			bridgeEnable        <= bridge_d;
			absolutePosition    <= absPos_d;
			markPosition        <= markPos_d;
			target_q            <= target_d;
			accelSteps_q        <= accelSteps_d;
			untilSpeed_q        <= untilSpeed_d;
			dir_q               <= dir_d;
			act_q               <= act_d;
			swPrev_q            <= swClosed;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			commandRejectedFlag <= 1'b0;
			wrongCommandFlag    <= 1'b0;
			err_q               <= 1'b0;
			swEvt_q             <= 1'b0;
			warn_q              <= '0;
			stepPulse           <= 1'b0;
		end else if (clkEn) begin
			commandRejectedFlag <= rej_d;
			wrongCommandFlag    <= wrong_d;
			err_q               <= err_d;
			swEvt_q             <= swEvt_d;
			warn_q              <= warn_d;
			stepPulse           <= stepApply;
		end
	end
	assign stepDir = dir_q;

	// high byte answers on the next exchange, low byte after
	// a fresh status read overwrites any pending byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txByte        <= 8'h00;
			respByte_q    <= 8'h00;
			respPending_q <= 1'b0;
		end else if (clkEn) begin
			if (statusCmd) begin
				txByte        <= statusWord[15:8];
				respByte_q    <= statusWord[7:0];
				respPending_q <= 1'b1;
			end else if (rxValid) begin
				txByte        <= respPending_q ? respByte_q : 8'h00;
				respPending_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	reject_flag_a: assert property (clkEn && rejectEvt |=> commandRejectedFlag)
		else $error("busy position move did not raise rejected flag");
	move_busy_a: assert property (clkEn && startPos |=> !busyN && state_q == MS_ABSOLUTE_MOVE)
		else $error("position move did not drive busy low");
	pos_clear_a: assert property (clkEn && cmdByte && opClear |=> absolutePosition == '0)
		else $error("position clear left nonzero position");
	imm_float_a: assert property (clkEn && hardFloatCmd |=> highImpedanceFlag)
		else $error("immediate float kept bridges on");
	stop_wake_a: assert property (clkEn && (softStopCmd || hardStopCmd) && !faultEvt
		|=> bridgeEnable && state_q == MS_IDLE || bridgeEnable && state_q == MS_DECEL)
		else $error("stop command did not enable bridges");
	status_msb_a: assert property (clkEn && statusCmd |=> txByte == $past(statusWord[15:8]))
		else $error("status read high byte wrong");
	status_keep_a: assert property (clkEn && statusCmd && !faultEvt && !unknownEvt
		|=> !wrongCommandFlag && !err_q
		&& highImpedanceFlag == $past(highImpedanceFlag))
		else $error("status read clear misbehaved");
	wrong_cmd_a: assert property (clkEn && unknownEvt |=> wrongCommandFlag)
		else $error("unknown byte not flagged");
	reinit_state_a: assert property (clkEn && reinit
		|=> highImpedanceFlag && absolutePosition == '0 && state_q == MS_IDLE)
		else $error("reinitialise did not restore power-up state");
	release_end_a: assert property (clkEn && releaseHit |=> state_q == MS_IDLE && stopped)
		else $error("release switch did not stop at once");
endmodule

// *** tb/host_model.sv ***
// Host side model: sends command and argument bytes as strobes.
// Assumes the core takes a byte at each edge with rxValid high.
`timescale 1ns/1ps
module host_model (
	input  wire logic       sys_clk,
	output logic            rxValid,
	output logic [7:0]      rxByte
);
	initial begin
		rxValid = 1'b0;
		rxByte  = 8'h00;
	end
	// Strobe idles a cycle; stale byte inverted
	task automatic send(input logic [7:0] b);
		@(posedge sys_clk);
		rxValid <= 1'b1;
		rxByte  <= b;
		@(posedge sys_clk);
		rxValid <= 1'b0;
		rxByte  <= ~b;
	endtask
endmodule

// *** tb/stepper_cmd_core_tb.sv ***
// Self-checking bench for the stepper command core.
// Assumes host_model and a short engine tick for speed.
`timescale 1ns/1ps
module stepper_cmd_core_tb;
	import stepper_cmd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic rxValid, swStop, busyN, rej, wrong, high_impedance_flag, stepDir;
	logic swIn, en, bridge, stepP;
	logic [7:0] rxByte, txByte, tgt;
	logic [SPD_W-1:0] maxSpd, minSpd;
	logic [ACC_W-1:0] acc, dec;
	logic [POS_W-1:0] absPos, mark;
	logic [15:0] st, stw;
	int bad_count = 0;
	int n_tests = 0;
	int nSteps = 0;
	always #4 sys_clk = ~sys_clk;
	host_model host_model_i (.sys_clk(sys_clk), .rxValid(rxValid), .rxByte(rxByte));
	stepper_cmd_core #(.TICK_CYC(2)) stepper_cmd_core_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.clkEn(en), .rxValid(rxValid), .rxByte(rxByte), .swClosed(swIn),
		.switchStopSelect(swStop), .lowSpeedOpt(1'b0), .maxSpeed(maxSpd), .minSpeed(minSpd),
		.accelValue(acc), .decelerationRegister(dec), .warnEvt(4'h0), .faultEvt(1'b0),
		.txByte(txByte), .busyN(busyN), .commandRejectedFlag(rej), .wrongCommandFlag(wrong),
		.highImpedanceFlag(high_impedance_flag), .bridgeEnable(bridge), .stepPulse(stepP), .stepDir(stepDir),
		.absolutePosition(absPos), .markPosition(mark), .statusWord(stw));
	// Step pulses last one cycle, so each is seen at one edge
	always @(posedge sys_clk)
		if (stepP === 1'b1)
			nSteps <= nSteps + 1;
	// Idle, stopped, floating; only the wrong-command bit varies
	function automatic logic [15:0] expStatus(input logic w);
		return {7'h00, w, 6'h00, 2'h3};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] b);
		host_model_i.send(b);
		@(posedge sys_clk);
		#1;
	endtask
	task automatic waitIdle;
		for (int i = 0; i < 20000 && busyN !== 1'b1; i++)
			@(posedge sys_clk);
		#1;
	endtask
	task automatic finish_test;
		$display("checks=%0d bad=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		{swStop, swIn, maxSpd, minSpd, acc, dec} = '0;
		en = 1'b1;
		void'($urandom(32'h8F4A));
		tgt = 8'h01 + 8'($urandom % 3);
		repeat (3) @(posedge sys_clk);
		swStop <= 1'($urandom);
		maxSpd <= 20'hFFFFF;
		minSpd <= {4'hF, 16'($urandom)};
		acc <= 12'h800 | 12'($urandom);
		dec <= 12'h800 | 12'($urandom);
		rst_n <= 1'b1;
		#1;
		chk(high_impedance_flag, 1);
		cmd(8'hFF);
		chk(wrong, 1);
		chk(stw, expStatus(1'b1));
		cmd(OP_STATUS_READ);
		st = expStatus(1'b1);
		chk(txByte, st[15:8]);
		cmd(OP_STATUS_READ);
		st = expStatus(1'b0);
		chk(txByte, st[15:8]);
		cmd(OP_NOP);
		chk(txByte, st[7:0]);
		chk(high_impedance_flag, 1);
		chk(wrong, 0);
		$display("status test done");
		cmd(OP_ABRUPT_STOP);
		chk(high_impedance_flag, 0);
		chk(bridge, 1);
		cmd(OP_MOVE_DIR | 8'h01);
		cmd(8'h00);
		cmd(8'h00);
		cmd(tgt);
		@(posedge sys_clk);
		#1;
		chk(busyN, 0);
		cmd(($urandom % 2) ? OP_GO_ZERO : OP_GO_MARKER);
		chk(rej, 1);
		waitIdle();
		chk(busyN, 1);
		chk(nSteps, tgt);
		chk(absPos, 32'(tgt));
		chk(stepDir, 1);
		$display("move test done");
		// Homing run with marker load; speed argument below minimum
		cmd(OP_RUN_SWITCH | 8'h09);
		cmd(8'h00);
		cmd(8'h00);
		cmd(8'h00);
		chk(busyN, 0);
		// Switch closes long before the first step, so position stays put
		repeat (20) @(posedge sys_clk);
		swIn <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(busyN, !swStop);
		waitIdle();
		chk(busyN, 1);
		chk(mark, tgt);
		chk(absPos, tgt);
		cmd(OP_RELEASE_SW);
		chk(busyN, 0);
		@(posedge sys_clk);
		swIn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(busyN, 1);
		chk(absPos, 0);
		cmd(OP_GO_MARKER);
		waitIdle();
		chk(absPos, tgt);
		chk(stepDir, 1);
		$display("switch test done");
		cmd(OP_POS_CLEAR);
		chk(absPos, 0);
		cmd(OP_DECEL_FLOAT);
		chk(high_impedance_flag, 1);
		cmd(OP_DECEL_STOP);
		chk(high_impedance_flag, 0);
		chk(busyN, 1);
		cmd(OP_IMM_FLOAT);
		chk(high_impedance_flag, 1);
		// Frozen core must ignore the stop byte
		@(posedge sys_clk);
		en <= 1'b0;
		cmd(OP_ABRUPT_STOP);
		chk(high_impedance_flag, 1);
		@(posedge sys_clk);
		en <= 1'b1;
		cmd(8'hFF);
		cmd(OP_REINIT);
		chk(high_impedance_flag, 1);
		chk(wrong, 0);
		chk(rej, 0);
		$display("stop test done");
		finish_test();
	end
	initial begin
		#240000;
		bad_count++;
		finish_test();
	end
endmodule
